/* File: hdl/xcvr_flags_regs.vh */
// constants for the transceiver status flag block
`ifndef XCVR_FLAGS_REGS_VH
`define XCVR_FLAGS_REGS_VH
// register byte offsets
`define OFS_STATUS     4'h0
`define OFS_IRQ_STATUS 4'h4
`define OFS_IRQ_MASK   4'h8
`define OFS_CTRL       4'hC
// operating mode codes
`define MODE_NORMAL    3'h0
`define MODE_SILENT    3'h1
`define MODE_STANDBY   3'h2
`define MODE_GTS       3'h3
`define MODE_SLEEP     3'h4
// reset values
`define CTRL_RST       3'h2
`define MASK_RST       5'h00
// status bit positions
`define ST_PWR         0
`define ST_WRQ         1
`define ST_SRC_VALID   2
`define ST_SRC_LOCAL   3
`define ST_UV_CORE     4
`define ST_UV_IO       5
`define ST_MODE_LSB    8
// interrupt bit positions
`define IRQ_PWR        0
`define IRQ_WRQ        1
`define IRQ_UV_CORE    2
`define IRQ_UV_IO      3
`define IRQ_GTS_BLOCK  4
`define IRQ_W          5
// timing
`define CLK_MHZ        250
`define UV_FILTER_MS   159
`define UV_FILTER_CYC  (`UV_FILTER_MS * 1000 * `CLK_MHZ)
`define TXD_EDGES_CLR  3'h4
`endif

/* File: hdl/xcvr_flags.v */
// status flag and indicator logic of a can transceiver
`timescale 1ns/1ns
//
// Functional notes
// RULE_01: receive output also shows pending wake request
// RULE_02: all fault conditions ored onto fault output
// RULE_03: power-up flag set at battery power-up/return
// RULE_04: power-up flag cleared entering normal mode
// RULE_05: wake request on bus, local, power-up
// RULE_06: wake request set only in low-power modes
// RULE_07: wake drives fault and receive outputs low
// RULE_08: wake request cleared by normal or undervoltage
// RULE_09: wake request restarts undervoltage filter timers
// RULE_10: normal mode shows local wake as low
// RULE_11: normal mode shows bus wake as high
// RULE_12: wake source cleared by edges, exit, undervoltage
// RULE_13: power-up sets wake source to local
// RULE_14: undervoltage flags cleared on return or wake
// RULE_15: go-to-sleep blocked while wake request set
// RULE_16: wake source keeps the first source only
// RULE_17: undervoltage flag only after filter time
// RULE_18: power-up flag shown low entering silent
`include "xcvr_flags_regs.vh"

module xcvr_flags
#(
  parameter UV_FILTER_CYCLES = `UV_FILTER_CYC
)
(
  input  wire        core_clk,
  input  wire        srst,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire        irq,
  input  wire        battery_supply,
  input  wire        core_supply_ok,
  input  wire        io_supply_ok,
  input  wire        bus_wake_event,
  input  wire        local_wake_event,
  input  wire        txd,
  input  wire        bus_rxd,
  input  wire        other_fault,
  output reg         fault_indicator_n,
  output reg         rxd_out,
  output wire [2:0]  mode
);

  // low-power modes: standby, go-to-sleep, sleep
  function is_low_power;
    input [2:0] m;
    begin
      is_low_power = (m == `MODE_STANDBY) || (m == `MODE_GTS) ||
                     (m == `MODE_SLEEP);
    end
  endfunction

  // pin synchroniser, two stages; stage one is read by stage two only
  reg  [7:0] sync1_reg;        // first stage
  reg  [7:0] sync2_reg;        // second stage, safe to use
  reg  [7:0] prev_reg;         // previous second-stage values, for edges
  wire [7:0] pins_in;          // raw pins
  assign pins_in = {other_fault, bus_rxd, txd, local_wake_event,
                    bus_wake_event, io_supply_ok, core_supply_ok,
                    battery_supply};
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      prev_reg  <= 8'h00;
    end
    else
    begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire battery_supply_ok   = sync2_reg[0];
  wire vcc_ok    = sync2_reg[1];
  wire vio_ok    = sync2_reg[2];
  wire fault_any = sync2_reg[7];           // external faults
  // battery returns above its threshold
  wire battery_supply_rise = battery_supply_ok & ~prev_reg[0];
  // bus wake arrives as a rising level from the wake filter
  wire bus_wake  = sync2_reg[3] & ~prev_reg[3];
  // local wake is any state change of the wake input
  wire loc_wake  = sync2_reg[4] ^ prev_reg[4];
  // recessive to dominant on transmit input is high to low
  wire txd_fall  = ~sync2_reg[5] & prev_reg[5];

  // operating mode, requested by software
  reg  [2:0] mode_reg;
  reg  [2:0] mode_next;
  reg  [2:0] ctrl_reg;         // requested mode
  reg        gts_block;        // refused go-to-sleep request
  reg        wrq_flag_reg;     // wake_request_flag
  always @*
  begin
    mode_next = ctrl_reg;
    gts_block = 1'b0;
    if (battery_supply_rise)
      mode_next = `MODE_STANDBY;   // battery return restarts in standby
    else if (ctrl_reg == `MODE_GTS && mode_reg != `MODE_GTS &&
             wrq_flag_reg)
    begin
      mode_next = mode_reg;        // [RULE_15]
      gts_block = 1'b1;
    end
  end
  always @(posedge core_clk)
  begin
    if (srst)
      mode_reg <= `MODE_STANDBY;
    else
      mode_reg <= mode_next;
  end
  assign mode = mode_reg;

  wire enter_normal = (mode_next == `MODE_NORMAL) &&
                      (mode_reg != `MODE_NORMAL);
  wire leave_normal = (mode_next != `MODE_NORMAL) &&
                      (mode_reg == `MODE_NORMAL);
  wire enter_silent = (mode_next == `MODE_SILENT) &&
                      is_low_power(mode_reg);

  // wake events only count in low-power modes
  wire wake_set = (bus_wake | loc_wake) & is_low_power(mode_reg); // [RULE_06]

  // undervoltage filters for core and io supplies
  reg  [25:0] uv_cnt_reg [0:1];
  reg  [1:0]  uv_flag_reg;     // core_supply_undervolt_flag, io_...
  wire [1:0]  sup_ok = {vio_ok, vcc_ok};
  wire        wrq_set;
  wire [1:0]  uv_rise;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : uv_filter
      // count while the supply stays low; restart on a wake request
      always @(posedge core_clk)
      begin
        if (srst || sup_ok[g] || wrq_set)
          uv_cnt_reg[g] <= 26'h0000000;        // [RULE_09]
        else if (uv_cnt_reg[g] != UV_FILTER_CYCLES[25:0])
          uv_cnt_reg[g] <= uv_cnt_reg[g] + 26'h0000001;
      end
      // flag after the full filter time; read back in the status word
      always @(posedge core_clk)
      begin
        if (srst || sup_ok[g] || wrq_set)
          uv_flag_reg[g] <= 1'b0;              // [RULE_14]
        else if (uv_cnt_reg[g] == UV_FILTER_CYCLES[25:0])
          uv_flag_reg[g] <= 1'b1;              // [RULE_17]
      end
      assign uv_rise[g] = ~sup_ok[g] & ~wrq_set & ~uv_flag_reg[g] &
                          (uv_cnt_reg[g] == UV_FILTER_CYCLES[25:0]);
    end
  endgenerate
  wire uv_event = |uv_rise;

  // wake request: set wins over clear
  assign wrq_set = wake_set | battery_supply_rise;        // [RULE_05]
  always @(posedge core_clk)
  begin
    if (srst || wrq_set)
      wrq_flag_reg <= 1'b1;                     // also initial power-up
    else if (enter_normal || uv_event)
      wrq_flag_reg <= 1'b0;                     // [RULE_08]
  end

  // power-up flag
  reg pwr_flag_reg;            // power_up_flag
  always @(posedge core_clk)
  begin
    if (srst || battery_supply_rise)
      pwr_flag_reg <= 1'b1;                     // [RULE_03]
    else if (enter_normal)
      pwr_flag_reg <= 1'b0;                     // [RULE_04]
  end

  // wake source: valid bit plus local/bus, first source kept
  reg       src_valid_reg;
  reg       src_local_reg;     // wake_source_flag, 1 = local
  reg [2:0] edge_cnt_reg;      // transmit edges seen in normal mode
  wire      in_normal = (mode_reg == `MODE_NORMAL);
  wire      edges_done = in_normal && txd_fall &&
                         (edge_cnt_reg == `TXD_EDGES_CLR - 3'h1);
  always @(posedge core_clk)
  begin
    if (srst || battery_supply_rise)
    begin
      src_valid_reg <= 1'b1;                    // [RULE_13]
      src_local_reg <= 1'b1;
    end
    else if (wake_set && !src_valid_reg)
    begin
      src_valid_reg <= 1'b1;                    // [RULE_16]
      src_local_reg <= loc_wake;
    end
    else if (edges_done || leave_normal || uv_event)
    begin
      src_valid_reg <= 1'b0;                    // [RULE_12]
      src_local_reg <= 1'b0;                    // no stale local source
    end
  end
  // count recessive to dominant edges only in normal mode
  always @(posedge core_clk)
  begin
    if (srst || !in_normal || edges_done)
      edge_cnt_reg <= 3'h0;
    else if (txd_fall)
      edge_cnt_reg <= edge_cnt_reg + 3'h1;
  end

  // silent-mode power-up indication, latched on entry
  reg silent_pwr_reg;
  always @(posedge core_clk)
  begin
    if (srst)
      silent_pwr_reg <= 1'b0;
    else if (enter_silent)
      silent_pwr_reg <= pwr_flag_reg;           // [RULE_18]
    else if (mode_reg != `MODE_SILENT)
      silent_pwr_reg <= 1'b0;
  end

  // indicator outputs, registered
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      fault_indicator_n <= 1'b1;
      rxd_out           <= 1'b1;
    end
    else if (is_low_power(mode_reg))
    begin
      // both pins low while a wake is pending
      fault_indicator_n <= ~(fault_any | wrq_flag_reg); // [RULE_07]
      rxd_out           <= ~wrq_flag_reg;               // [RULE_01]
    end
    else if (in_normal)
    begin
      // local wake low, bus wake high, faults ored in
      fault_indicator_n <= ~(fault_any |        // [RULE_02]
        (src_valid_reg & src_local_reg)); // [RULE_10] [RULE_11]
      rxd_out           <= sync2_reg[6];
    end
    else
    begin
      fault_indicator_n <= ~(fault_any | silent_pwr_reg);
      rxd_out           <= sync2_reg[6];
    end
  end

  // interrupt events and sticky status, write one to clear
  wire [`IRQ_W-1:0] irq_evt;
  reg  [`IRQ_W-1:0] irq_stat_reg;
  reg  [`IRQ_W-1:0] irq_mask_reg;
  reg               ack_reg;       // bus answer cycle
  wire              wr_ack = avs_write & ack_reg;
  assign irq_evt = {gts_block, uv_rise, wrq_set, battery_supply_rise};
  generate
    for (g = 0; g < `IRQ_W; g = g + 1)
    begin : irq_bits
      // an event in the clearing cycle wins
      always @(posedge core_clk)
      begin
        if (srst)
          irq_stat_reg[g] <= 1'b0;
        else if (irq_evt[g])
          irq_stat_reg[g] <= 1'b1;
        else if (wr_ack && avs_address[3:2] == `OFS_IRQ_STATUS >> 2 &&
                 avs_writedata[g])
          irq_stat_reg[g] <= 1'b0;
      end
    end
  endgenerate
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // avalon slave: one wait cycle, answer on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  always @(posedge core_clk)
  begin
    if (srst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  // writable registers
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      ctrl_reg     <= `CTRL_RST;
      irq_mask_reg <= `MASK_RST;
    end
    else
    begin
      if (wr_ack && avs_address[3:2] == 2'h2)
        irq_mask_reg <= avs_writedata[`IRQ_W-1:0];
      // a battery return must not fall back to the old requested mode
      if (battery_supply_rise)
        ctrl_reg <= `MODE_STANDBY;
      else if (wr_ack && avs_address[3:2] == 2'h3)
        ctrl_reg <= avs_writedata[2:0];
    end
  end

  // read data sampled in the wait cycle, stands in the answer cycle
  wire [31:0] status_word = {21'h000000, mode_reg, 2'h0,
                             uv_flag_reg[1], uv_flag_reg[0],
                             src_local_reg, src_valid_reg,
                             wrq_flag_reg, pwr_flag_reg};
  always @(posedge core_clk)
  begin
    if (srst)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !ack_reg)
    begin
      case (avs_address[3:2])
        2'h0:    avs_readdata <= status_word;
        2'h1:    avs_readdata <= {27'h0000000, irq_stat_reg};
        2'h2:    avs_readdata <= {27'h0000000, irq_mask_reg};
        2'h3:    avs_readdata <= {29'h00000000, ctrl_reg};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule // xcvr_flags

/* File: test/xcvr_flags_properties.sv */
// assertion checker for the transceiver status flag block
`timescale 1ns/1ns
`include "xcvr_flags_regs.vh"

module xcvr_flags_props
#(
  parameter UV_FILTER_CYCLES = 20
)
(
  input wire        core_clk,
  input wire        srst,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire        avs_waitrequest,
  input wire        irq,
  input wire        local_wake_event,
  input wire        bus_rxd,
  input wire        other_fault,
  input wire        fault_indicator_n,
  input wire        rxd_out,
  input wire [2:0]  mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // completed control write; gts is left out, it may be refused
  wire       ctrl_wr = avs_write && !avs_waitrequest &&
                       avs_address == `OFS_CTRL;
  wire       ok_wr   = ctrl_wr && avs_writedata[2:0] != `MODE_GTS &&
                       avs_writedata[2:0] <= `MODE_SLEEP;
  reg  [2:0] want_reg; // mode last written to the control word
  // capture the requested mode at the completing edge
  always @(posedge core_clk)
    if (ctrl_wr)
      want_reg <= avs_writedata[2:0];

  a_wait_answer: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("bus not answered");
  a_mode_follow: assert property (ok_wr |-> ##2 mode == want_reg)
    else $error("mode did not follow control");
  a_irq_quiet: assert property ($fell(srst) |-> !irq)
    else $error("interrupt raised with mask cleared");
  a_rxd_follow: assert property (
    ((mode == `MODE_NORMAL) && $stable(bus_rxd)) [*6] |-> rxd_out == bus_rxd)
    else $error("receive output not following bus");
  a_fault_or: assert property (
    other_fault [*5] |-> !fault_indicator_n)
    else $error("fault not shown on fault output");
  a_wake_both: assert property (
    ((mode >= `MODE_STANDBY) && !rxd_out) [*2] |-> !fault_indicator_n)
    else $error("wake shown on receive output only");
  a_wake_rxd: assert property (
    mode == `MODE_STANDBY && $changed(local_wake_event) |-> ##[1:6] !rxd_out)
    else $error("local wake not signalled");
  a_gts_refused: assert property (
    ctrl_wr && avs_writedata[2:0] == `MODE_GTS && mode == `MODE_STANDBY &&
    !rxd_out |=> (mode != `MODE_GTS) [*4])
    else $error("go-to-sleep taken with wake pending");

  c_silent: cover property (mode == `MODE_SILENT && !fault_indicator_n);
  c_normal: cover property (mode == `MODE_NORMAL && fault_indicator_n);
  c_irq: cover property (irq);
  c_sleep_wake: cover property (mode == `MODE_SLEEP && !rxd_out);
endmodule // xcvr_flags_props

bind xcvr_flags xcvr_flags_props #(.UV_FILTER_CYCLES(UV_FILTER_CYCLES)) chk_u
(
  .core_clk(core_clk), .srst(srst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .irq(irq),
  .local_wake_event(local_wake_event), .bus_rxd(bus_rxd),
  .other_fault(other_fault), .fault_indicator_n(fault_indicator_n),
  .rxd_out(rxd_out), .mode(mode)
);

/* File: test/host_mcu.sv */
// host controller model that drives the transmit input
`timescale 1ns/1ns

module host_mcu
(
  input  wire core_clk,
  output reg  txd
);
  initial txd = 1'h1; // recessive while idle
  // n dominant bits of four cycles, each one a falling edge
  task send(input integer n);
    integer i;
    for (i = 0; i < n; i = i + 1)
    begin
      @(posedge core_clk) txd <= 1'h0;
      repeat (4) @(posedge core_clk);
      txd <= 1'h1;
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule // host_mcu

/* File: test/xcvr_flags_tb.sv */
// self-checking bench for the transceiver status flag block
`timescale 1ns/1ns
`include "xcvr_flags_regs.vh"

module xcvr_flags_tb;
  reg         core_clk = 1'h0;
  reg         srst = 1'h1;
  reg  [3:0]  avs_address = 4'h0;
  reg         avs_read = 1'h0;
  reg         avs_write = 1'h0;
  reg  [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, irq, fault_indicator_n, rxd_out, txd;
  wire [2:0]  mode;
  reg         battery_supply = 1'h1;
  reg  [1:0]  sup = 2'h3; // {io, core} good
  reg         bus_wake_event = 1'h0;
  reg         local_wake_event = 1'h0;
  reg         bus_rxd = 1'h1;
  reg         other_fault = 1'h0;
  reg         b;          // random receive level
  reg  [31:0] q;          // last read word
  integer     seed = 92126;
  integer     k, r, miscompares = 0, total_checks = 0;

  xcvr_flags #(.UV_FILTER_CYCLES(20)) dut_u
  (
    .core_clk(core_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq),
    .battery_supply(battery_supply), .core_supply_ok(sup[0]),
    .io_supply_ok(sup[1]), .bus_wake_event(bus_wake_event),
    .local_wake_event(local_wake_event), .txd(txd), .bus_rxd(bus_rxd),
    .other_fault(other_fault), .fault_indicator_n(fault_indicator_n),
    .rxd_out(rxd_out), .mode(mode)
  );
  host_mcu host_u (.core_clk(core_clk), .txd(txd));

  always #2 core_clk = ~core_clk;
  task cyc(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  // one bus access; request held until waitrequest is seen low
  task bus(input w, input [3:0] a, input [31:0] d);
    @(posedge core_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'h0)
      @(posedge core_clk);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task pin(input g, input e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task wr(input [3:0] a, input [31:0] d);
    bus(1'h1, a, d);
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      bus(1'h0, a, 32'h0);
      chk(q, e);
    end
  endtask
  // expected status word: flag bits and mode field
  function [31:0] st(input [5:0] f, input [2:0] m);
    st = {21'h0, m, 2'h0, f};
  endfunction
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // watchdog: the whole run needs well under 3000 cycles
  initial
  begin
    cyc(5000);
    miscompares = miscompares + 1;
    results;
  end

  initial
  begin
    cyc(12);
    srst <= 1'h0;
    cyc(10);
    rd(`OFS_STATUS, st(6'h0F, `MODE_STANDBY));
    pin(fault_indicator_n, 1'h0);
    pin(rxd_out, 1'h0);
    rd(`OFS_CTRL, 32'h2);
    rd(`OFS_IRQ_MASK, 32'h0);
    pin(irq, 1'h0);
    wr(`OFS_IRQ_MASK, 32'h1F);
    cyc(2);
    pin(irq, 1'h1);
    wr(`OFS_IRQ_STATUS, 32'h1F);
    cyc(2);
    pin(irq, 1'h0);
    wr(`OFS_CTRL, 32'h3);
    cyc(4);
    rd(`OFS_STATUS, st(6'h0F, `MODE_STANDBY));
    rd(`OFS_IRQ_STATUS, 32'h10);
    pin(irq, 1'h1);
    wr(`OFS_IRQ_STATUS, 32'h1F);
    $display("test reset, interrupt and go-to-sleep done");
    wr(`OFS_CTRL, 32'h1);
    cyc(6);
    pin(fault_indicator_n, 1'h0);
    wr(`OFS_CTRL, 32'h0);
    local_wake_event <= ~local_wake_event; // ignored in normal mode
    cyc(6);
    rd(`OFS_STATUS, st(6'h0C, `MODE_NORMAL));
    pin(fault_indicator_n, 1'h0);
    for (k = 0; k < 6; k = k + 1)
    begin
      r = $random(seed);
      b = r[0];
      bus_rxd <= b;
      cyc(6);
      pin(rxd_out, b);
    end
    bus_rxd <= 1'h1;
    host_u.send(3);
    cyc(6);
    pin(fault_indicator_n, 1'h0);
    host_u.send(1);
    cyc(6);
    pin(fault_indicator_n, 1'h1);
    rd(`OFS_STATUS, st(6'h00, `MODE_NORMAL));
    other_fault <= 1'h1;
    cyc(6);
    pin(fault_indicator_n, 1'h0);
    other_fault <= 1'h0;
    $display("test silent and normal mode done");
    wr(`OFS_CTRL, 32'h2);
    cyc(4);
    bus_wake_event <= 1'h1;
    cyc(2);
    bus_wake_event <= 1'h0;
    cyc(6);
    pin(rxd_out, 1'h0);
    pin(fault_indicator_n, 1'h0);
    local_wake_event <= ~local_wake_event; // later source must not win
    cyc(6);
    wr(`OFS_CTRL, 32'h0);
    cyc(6);
    pin(fault_indicator_n, 1'h1);
    rd(`OFS_STATUS, st(6'h04, `MODE_NORMAL));
    $display("test bus wake done");
    wr(`OFS_CTRL, 32'h2);
    cyc(4);
    rd(`OFS_STATUS, st(6'h00, `MODE_STANDBY));
    for (k = 0; k < 2; k = k + 1)
    begin
      sup[k] <= 1'h0; // short dip, shorter than the filter
      cyc(10);
      sup[k] <= 1'h1;
      cyc(4);
      rd(`OFS_STATUS, st(6'h00, `MODE_STANDBY));
      local_wake_event <= ~local_wake_event;
      cyc(6);
      sup[k] <= 1'h0;
      cyc(30);
      rd(`OFS_STATUS, st(6'h10 << k, `MODE_STANDBY));
      sup[k] <= 1'h1;
      cyc(6);
      rd(`OFS_STATUS, st(6'h00, `MODE_STANDBY));
    end
    sup[0] <= 1'h0; // a wake in mid-dip restarts the filter
    cyc(12);
    local_wake_event <= ~local_wake_event;
    cyc(12);
    rd(`OFS_STATUS, st(6'h0E, `MODE_STANDBY));
    sup[0] <= 1'h1;
    $display("test undervoltage done");
    wr(`OFS_CTRL, 32'h0);
    cyc(4);
    wr(`OFS_CTRL, 32'h3); // allowed now, no wake pending
    cyc(4);
    rd(`OFS_STATUS, st(6'h00, `MODE_GTS));
    wr(`OFS_CTRL, 32'h4);
    cyc(4);
    bus_wake_event <= 1'h1;
    cyc(2);
    bus_wake_event <= 1'h0;
    cyc(6);
    rd(`OFS_STATUS, st(6'h06, `MODE_SLEEP));
    pin(rxd_out, 1'h0);
    pin(fault_indicator_n, 1'h0);
    $display("test go-to-sleep and sleep done");
    battery_supply <= 1'h0;
    cyc(8);
    battery_supply <= 1'h1;
    cyc(10);
    rd(`OFS_STATUS, st(6'h0F, `MODE_STANDBY));
    $display("test battery return done");
    results;
  end
endmodule // xcvr_flags_tb
